//--- encres_pkg.sv
package encres_pkg;
  localparam logic [31:0] resume_leaf = 32'h0000_0003;
  localparam int addr_w = 8;
  localparam logic [7:0] off_ctrl     = 8'h00;
  localparam logic [7:0] off_leaf     = 8'h04;
  localparam logic [7:0] off_tcs_addr = 8'h08;
  localparam logic [7:0] off_aep_in   = 8'h0c;
  localparam logic [7:0] off_tcs_flg  = 8'h10;
  localparam logic [7:0] off_tcs_stat = 8'h14;
  localparam logic [7:0] off_fs_ofs   = 8'h18;
  localparam logic [7:0] off_gs_ofs   = 8'h1c;
  localparam logic [7:0] off_fs_lim   = 8'h20;
  localparam logic [7:0] off_gs_lim   = 8'h24;
  localparam logic [7:0] off_enclave_control_struct_bas = 8'h28;
  localparam logic [7:0] off_ds_lim   = 8'h2c;
  localparam logic [7:0] off_seg_nz   = 8'h30;
  localparam logic [7:0] off_feature_request_mask     = 8'h34;
  localparam logic [7:0] off_ext_control_reg_zero     = 8'h38;
  localparam logic [7:0] off_xs_bv    = 8'h3c;
  localparam logic [7:0] off_xs_rsvd  = 8'h40;
  localparam logic [7:0] off_status   = 8'h44;
  localparam logic [7:0] off_sav_ext_control_reg_zero = 8'h48;
  localparam logic [7:0] off_fs_base  = 8'h4c;
  localparam logic [7:0] off_gs_base  = 8'h50;
  localparam logic [7:0] off_tcs_aep  = 8'h54;
  localparam logic [7:0] off_pgs_hi   = 8'h58;
  // ctrl bits
  localparam int c_go      = 0;
  localparam int c_wide    = 1;
  localparam int c_osxs    = 2;
  localparam int c_xs_av   = 3;
  localparam int c_tf      = 4;
  localparam int c_flags_pop_instr    = 5;
  localparam int c_exit    = 6;
  localparam int c_anythr  = 7;
  // tcs_stat bits
  localparam int t_valid   = 0;
  localparam int t_avail   = 1;
  localparam int t_locked  = 2;
  localparam int t_wattr   = 3;
  localparam int t_ssa_ok  = 4;
  localparam int t_ssa_use = 5;
  localparam int t_fs_fit  = 6;
  // status bits
  localparam int s_busy    = 0;
  localparam int s_inside  = 1;
  localparam int s_fault   = 2;
  localparam int s_sspend  = 3;
  localparam int s_tf_sav  = 4;
  localparam int s_tf_cur  = 5;
  localparam int s_code_lo = 8;
  localparam int tcs_align_bits = 12;
  localparam logic [31:0] tcs_flag_rsvd = 32'hffff_fffe;
  localparam int flag_optin = 0;
  localparam logic [31:0] feature_request_mask_legacy = 32'h0000_0003;
  localparam int pgs_bit60 = 28;
  localparam int pgs_bit63 = 31;
  typedef enum logic [3:0] {
    encres_f_none, encres_f_leaf, encres_f_align, encres_f_flags,
    encres_f_tcs, encres_f_mode, encres_f_segbase, encres_f_fsgs,
    encres_f_feature_request_mask, encres_f_ext_control_reg_zero, encres_f_hdr, encres_f_bv, encres_f_ssa
  } encres_fault_e;
endpackage

//--- encres_top.sv
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/10ps
module encres_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             single_step_trap,
  output logic             code_bp_outside_off,
  output logic             bp_inside_off,
  output logic             perf_suppress,
  output logic             demote_other_threads
);
  typedef enum logic [1:0] {encres_idle, encres_check, encres_commit}
    encres_st_e;

  encres_st_e    st_ff;
  logic [31:0]   ctrl_ff;
  logic [31:0]   leaf_ff;
  logic [31:0]   tcs_addr_ff;
  logic [31:0]   aep_in_ff;
  logic [31:0]   tcs_flg_ff;
  logic [31:0]   tcs_stat_ff;
  logic [31:0]   fs_ofs_ff;
  logic [31:0]   gs_ofs_ff;
  logic [31:0]   fs_lim_ff;
  logic [31:0]   gs_lim_ff;
  logic [31:0]   enclave_control_struct_bas_ff;
  logic [31:0]   ds_lim_ff;
  logic [31:0]   seg_nz_ff;
  logic [31:0]   feature_request_mask_ff;
  logic [31:0]   ext_control_reg_zero_ff;
  logic [31:0]   xs_bv_ff;
  logic [31:0]   xs_rsvd_ff;
  logic [31:0]   sav_ext_control_reg_zero_ff;
  logic [31:0]   fs_base_ff;
  logic [31:0]   gs_base_ff;
  logic [31:0]   sav_fs_ff;
  logic [31:0]   sav_gs_ff;
  logic [31:0]   tcs_aep_ff;
  logic [31:0]   pgs_hi_ff;
  logic          inside_ff;
  logic          optout_ff;
  logic          tf_sav_ff;
  logic          tf_cur_ff;
  logic          sspend_ff;
  logic          fault_ff;
  encres_pkg::encres_fault_e code_ff;
  encres_pkg::encres_fault_e nxt_code;
  logic [31:0]   nxt_rdata;
  logic          wr_en;
  logic          rd_en;
  logic          hit;
  logic          go;
  logic          exit_ev;
  logic          flags_pop_instr_ev;
  logic          wide;

  // true when base+offset .. +limit stays inside the data segment
  function automatic logic seg_fits(input logic [31:0] ofs,
                                    input logic [31:0] lim,
                                    input logic [31:0] base,
                                    input logic [31:0] dslim);
    logic [31:0] b;
    logic [31:0] l;
    b = ofs + base;
    l = b + lim;
    if (l < b) begin
      seg_fits = (dslim == 32'hffff_ffff);
    end else begin
      seg_fits = (l <= dslim);
    end
  endfunction

  function automatic logic in_map(input logic [7:0] a);
    in_map = (a[1:0] == 2'b00) && (a <= encres_pkg::off_pgs_hi);
  endfunction

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite && hit;
  assign rd_en   = psel && !penable && !pwrite;
  assign hit     = in_map(paddr);
  assign go      = wr_en && (paddr == encres_pkg::off_ctrl) &&
                   pwdata[encres_pkg::c_go] && (st_ff == encres_idle);
  assign exit_ev = wr_en && (paddr == encres_pkg::off_ctrl) &&
                   pwdata[encres_pkg::c_exit] && inside_ff;
  assign flags_pop_instr_ev = wr_en && (paddr == encres_pkg::off_ctrl) &&
                   pwdata[encres_pkg::c_flags_pop_instr];
  assign wide    = ctrl_ff[encres_pkg::c_wide];

  // inputs are frozen while a resume is in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff     <= 32'h0000_0000;
      leaf_ff     <= 32'h0000_0000;
      tcs_addr_ff <= 32'h0000_0000;
      aep_in_ff   <= 32'h0000_0000;
      tcs_flg_ff  <= 32'h0000_0000;
      tcs_stat_ff <= 32'h0000_0000;
      fs_ofs_ff   <= 32'h0000_0000;
      gs_ofs_ff   <= 32'h0000_0000;
      fs_lim_ff   <= 32'h0000_0000;
      gs_lim_ff   <= 32'h0000_0000;
      enclave_control_struct_bas_ff <= 32'h0000_0000;
      ds_lim_ff   <= 32'h0000_0000;
      seg_nz_ff   <= 32'h0000_0000;
      feature_request_mask_ff     <= 32'h0000_0000;
      ext_control_reg_zero_ff     <= 32'h0000_0000;
      xs_bv_ff    <= 32'h0000_0000;
      xs_rsvd_ff  <= 32'h0000_0000;
    end else if (wr_en && (st_ff == encres_idle)) begin
      case (paddr)
        encres_pkg::off_ctrl: begin
          ctrl_ff <= pwdata;
          // exit arrives as a control write, so the mask swap is undone here
          if (exit_ev && ctrl_ff[encres_pkg::c_osxs]) begin
            ext_control_reg_zero_ff <= sav_ext_control_reg_zero_ff;
          end
        end
        encres_pkg::off_leaf:     leaf_ff     <= pwdata;
        encres_pkg::off_tcs_addr: tcs_addr_ff <= pwdata;
        encres_pkg::off_aep_in:   aep_in_ff   <= pwdata;
        encres_pkg::off_tcs_flg:  tcs_flg_ff  <= pwdata;
        encres_pkg::off_tcs_stat: tcs_stat_ff <= pwdata;
        encres_pkg::off_fs_ofs:   fs_ofs_ff   <= pwdata;
        encres_pkg::off_gs_ofs:   gs_ofs_ff   <= pwdata;
        encres_pkg::off_fs_lim:   fs_lim_ff   <= pwdata;
        encres_pkg::off_gs_lim:   gs_lim_ff   <= pwdata;
        encres_pkg::off_enclave_control_struct_bas: enclave_control_struct_bas_ff <= pwdata;
        encres_pkg::off_ds_lim:   ds_lim_ff   <= pwdata;
        encres_pkg::off_seg_nz:   seg_nz_ff   <= pwdata;
        encres_pkg::off_feature_request_mask:     feature_request_mask_ff     <= pwdata;
        encres_pkg::off_ext_control_reg_zero: begin
          if (!inside_ff) begin
            ext_control_reg_zero_ff <= pwdata;
          end
        end
        encres_pkg::off_xs_bv:    xs_bv_ff    <= pwdata;
        encres_pkg::off_xs_rsvd:  xs_rsvd_ff  <= pwdata;
        default: ;
      endcase
    end else if (st_ff == encres_commit) begin
      if (ctrl_ff[encres_pkg::c_osxs]) begin
        ext_control_reg_zero_ff <= feature_request_mask_ff;
      end
    end
  end

  // fault priority follows the order the checks are evaluated in
  always_comb begin
    nxt_code = encres_pkg::encres_f_none;
    if (leaf_ff != encres_pkg::resume_leaf) begin
      nxt_code = encres_pkg::encres_f_leaf;
    end else if (tcs_addr_ff[encres_pkg::tcs_align_bits-1:0] != 12'h000)
    begin
      nxt_code = encres_pkg::encres_f_align;
    end else if ((tcs_flg_ff & encres_pkg::tcs_flag_rsvd) != 32'h0) begin
      nxt_code = encres_pkg::encres_f_flags;
    end else if (!tcs_stat_ff[encres_pkg::t_valid] ||
                 !tcs_stat_ff[encres_pkg::t_avail] ||
                 tcs_stat_ff[encres_pkg::t_locked]) begin
      nxt_code = encres_pkg::encres_f_tcs;
    end else if (wide != tcs_stat_ff[encres_pkg::t_wattr]) begin
      nxt_code = encres_pkg::encres_f_mode;
    end else if (!wide && (seg_nz_ff[3:0] != 4'h0)) begin
      nxt_code = encres_pkg::encres_f_segbase;
    end else if (!wide &&
                 (!seg_fits(fs_ofs_ff, fs_lim_ff, enclave_control_struct_bas_ff, ds_lim_ff) ||
                  !seg_fits(gs_ofs_ff, gs_lim_ff, enclave_control_struct_bas_ff, ds_lim_ff)))
    begin
      nxt_code = encres_pkg::encres_f_fsgs;
    end else if (ctrl_ff[encres_pkg::c_xs_av] &&
                 !ctrl_ff[encres_pkg::c_osxs] &&
                 (feature_request_mask_ff != encres_pkg::feature_request_mask_legacy)) begin
      nxt_code = encres_pkg::encres_f_feature_request_mask;
    end else if (ctrl_ff[encres_pkg::c_osxs] &&
                 ((feature_request_mask_ff & ~ext_control_reg_zero_ff) != 32'h0)) begin
      nxt_code = encres_pkg::encres_f_ext_control_reg_zero;
    end else if (xs_rsvd_ff != 32'h0) begin
      nxt_code = encres_pkg::encres_f_hdr;
    end else if ((xs_bv_ff & ~feature_request_mask_ff) != 32'h0) begin
      nxt_code = encres_pkg::encres_f_bv;
    end else if (!tcs_stat_ff[encres_pkg::t_ssa_ok] ||
                 tcs_stat_ff[encres_pkg::t_ssa_use]) begin
      nxt_code = encres_pkg::encres_f_ssa;
    end
  end

  // commit is only reached with no fault, so a fault leaves state alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff    <= encres_idle;
      fault_ff <= 1'b0;
      code_ff  <= encres_pkg::encres_f_none;
    end else begin
      case (st_ff)
        encres_idle: begin
          if (go) begin
            st_ff    <= encres_check;
            fault_ff <= 1'b0;
          end
        end
        encres_check: begin
          code_ff <= nxt_code;
          if (nxt_code != encres_pkg::encres_f_none) begin
            fault_ff <= 1'b1;
            st_ff    <= encres_idle;
          end else begin
            st_ff    <= encres_commit;
          end
        end
        encres_commit: st_ff <= encres_idle;
        default:       st_ff <= encres_idle;
      endcase
    end
  end

  // architectural swap on commit, undone on exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inside_ff   <= 1'b0;
      optout_ff   <= 1'b0;
      sav_ext_control_reg_zero_ff <= 32'h0000_0000;
      fs_base_ff  <= 32'h0000_0000;
      gs_base_ff  <= 32'h0000_0000;
      sav_fs_ff   <= 32'h0000_0000;
      sav_gs_ff   <= 32'h0000_0000;
      tcs_aep_ff  <= 32'h0000_0000;
    end else if (st_ff == encres_commit) begin
      inside_ff   <= 1'b1;
      optout_ff   <= !tcs_flg_ff[encres_pkg::flag_optin];
      tcs_aep_ff  <= aep_in_ff;
      sav_fs_ff   <= fs_base_ff;
      sav_gs_ff   <= gs_base_ff;
      fs_base_ff  <= fs_ofs_ff + enclave_control_struct_bas_ff;
      gs_base_ff  <= gs_ofs_ff + enclave_control_struct_bas_ff;
      if (ctrl_ff[encres_pkg::c_osxs]) begin
        sav_ext_control_reg_zero_ff <= ext_control_reg_zero_ff;
      end
    end else if (exit_ev) begin
      inside_ff  <= 1'b0;
      optout_ff  <= 1'b0;
      fs_base_ff <= sav_fs_ff;
      gs_base_ff <= sav_gs_ff;
    end
  end

  // single-step flag handling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tf_cur_ff <= 1'b0;
      tf_sav_ff <= 1'b0;
    end else if (st_ff == encres_commit) begin
      if (!tcs_flg_ff[encres_pkg::flag_optin]) begin
        tf_sav_ff <= tf_cur_ff;
        tf_cur_ff <= 1'b0;
      end
    end else if (exit_ev) begin
      if (optout_ff) begin
        tf_cur_ff <= tf_sav_ff;
      end
    end else if (flags_pop_instr_ev) begin
      tf_cur_ff <= pwdata[encres_pkg::c_tf] &&
                   !(inside_ff && optout_ff);
    end
  end

  // sticky pend: a new pend in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sspend_ff        <= 1'b0;
      single_step_trap <= 1'b0;
    end else begin
      single_step_trap <= (st_ff == encres_commit) &&
                          tcs_flg_ff[encres_pkg::flag_optin];
      if ((st_ff == encres_commit) && tcs_flg_ff[encres_pkg::flag_optin])
      begin
        sspend_ff <= 1'b1;
      end else if (wr_en && (paddr == encres_pkg::off_status) &&
                   pwdata[encres_pkg::s_sspend]) begin
        sspend_ff <= 1'b0;
      end
    end
  end

  // inside-breakpoint and perf suppression follow the entry kind; outside code breakpoints go off on every entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_bp_outside_off  <= 1'b0;
      bp_inside_off        <= 1'b0;
      perf_suppress        <= 1'b0;
      demote_other_threads <= 1'b0;
      pgs_hi_ff            <= 32'h0000_0000;
    end else if (st_ff == encres_commit) begin
      code_bp_outside_off <= 1'b1;
      bp_inside_off       <= !tcs_flg_ff[encres_pkg::flag_optin];
      // fixed counters one and two keep running outside this block
      perf_suppress       <= !tcs_flg_ff[encres_pkg::flag_optin];
      demote_other_threads <= !tcs_flg_ff[encres_pkg::flag_optin] &&
                              ctrl_ff[encres_pkg::c_anythr];
      if (!tcs_flg_ff[encres_pkg::flag_optin]) begin
        pgs_hi_ff[encres_pkg::pgs_bit60] <= 1'b1;
        pgs_hi_ff[encres_pkg::pgs_bit63] <= 1'b1;
      end
    end else if (exit_ev) begin
      code_bp_outside_off  <= 1'b0;
      bp_inside_off        <= 1'b0;
      perf_suppress        <= 1'b0;
      demote_other_threads <= 1'b0;
    end else if (wr_en && (paddr == encres_pkg::off_pgs_hi)) begin
      pgs_hi_ff <= pgs_hi_ff & ~pwdata;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (paddr)
      encres_pkg::off_ctrl:     nxt_rdata = ctrl_ff;
      encres_pkg::off_leaf:     nxt_rdata = leaf_ff;
      encres_pkg::off_tcs_addr: nxt_rdata = tcs_addr_ff;
      encres_pkg::off_aep_in:   nxt_rdata = aep_in_ff;
      encres_pkg::off_tcs_flg:  nxt_rdata = tcs_flg_ff;
      encres_pkg::off_tcs_stat: nxt_rdata = tcs_stat_ff;
      encres_pkg::off_fs_ofs:   nxt_rdata = fs_ofs_ff;
      encres_pkg::off_gs_ofs:   nxt_rdata = gs_ofs_ff;
      encres_pkg::off_fs_lim:   nxt_rdata = fs_lim_ff;
      encres_pkg::off_gs_lim:   nxt_rdata = gs_lim_ff;
      encres_pkg::off_enclave_control_struct_bas: nxt_rdata = enclave_control_struct_bas_ff;
      encres_pkg::off_ds_lim:   nxt_rdata = ds_lim_ff;
      encres_pkg::off_seg_nz:   nxt_rdata = seg_nz_ff;
      encres_pkg::off_feature_request_mask:     nxt_rdata = feature_request_mask_ff;
      encres_pkg::off_ext_control_reg_zero:     nxt_rdata = ext_control_reg_zero_ff;
      encres_pkg::off_xs_bv:    nxt_rdata = xs_bv_ff;
      encres_pkg::off_xs_rsvd:  nxt_rdata = xs_rsvd_ff;
      encres_pkg::off_status: begin
        nxt_rdata[encres_pkg::s_busy]   = (st_ff != encres_idle);
        nxt_rdata[encres_pkg::s_inside] = inside_ff;
        nxt_rdata[encres_pkg::s_fault]  = fault_ff;
        nxt_rdata[encres_pkg::s_sspend] = sspend_ff;
        nxt_rdata[encres_pkg::s_tf_sav] = tf_sav_ff;
        nxt_rdata[encres_pkg::s_tf_cur] = tf_cur_ff;
        nxt_rdata[encres_pkg::s_code_lo +: 4] = code_ff;
      end
      encres_pkg::off_sav_ext_control_reg_zero: nxt_rdata = sav_ext_control_reg_zero_ff;
      encres_pkg::off_fs_base:  nxt_rdata = fs_base_ff;
      encres_pkg::off_gs_base:  nxt_rdata = gs_base_ff;
      encres_pkg::off_tcs_aep:  nxt_rdata = tcs_aep_ff;
      encres_pkg::off_pgs_hi:   nxt_rdata = pgs_hi_ff;
      default:                  nxt_rdata = 32'h0000_0000;
    endcase
  end

  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= rd_en ? nxt_rdata : 32'h0000_0000;
      pslverr <= !hit;
    end
  end
endmodule

//--- encres_top_sva.sv
`timescale 1ns/10ps
module encres_top_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        single_step_trap,
  input wire logic        code_bp_outside_off,
  input wire logic        bp_inside_off,
  input wire logic        perf_suppress,
  input wire logic        demote_other_threads
);
  logic       ctl_wr;
  logic       go_wr;
  logic       ex_wr;
  logic [2:0] age_ff;
  assign ctl_wr = psel & penable & pwrite & (paddr == 8'h00);
  assign go_wr  = ctl_wr & pwdata[0];
  assign ex_wr  = ctl_wr & pwdata[6];
  // saturates so an old write never wraps back into range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      age_ff <= 3'h7;
    else if (ctl_wr)
      age_ff <= 3'h0;
    else if (age_ff != 3'h7)
      age_ff <= age_ff + 3'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_trap_pulse: assert property (
    single_step_trap |=> !single_step_trap)
    else $error("trap longer than one cycle");
  chk_trap_optin: assert property (
    single_step_trap |-> !bp_inside_off && !perf_suppress)
    else $error("trap with opt-out suppression");
  chk_trap_time: assert property (
    single_step_trap |-> $past(go_wr, 3) || $past(go_wr, 4))
    else $error("trap not tied to a start");
  chk_optout_pair: assert property (
    bp_inside_off |-> perf_suppress)
    else $error("breakpoint and perf suppression differ");
  chk_inside_code: assert property (
    bp_inside_off |-> code_bp_outside_off)
    else $error("outside breakpoints still live");
  chk_demote_optout: assert property (
    demote_other_threads |-> perf_suppress)
    else $error("demotion without opt-out");
  chk_rise_go: assert property (
    $rose(code_bp_outside_off) |-> age_ff inside {[3'h2:3'h3]})
    else $error("entry state at wrong time");
  chk_exit_drop: assert property (
    ex_wr && code_bp_outside_off |-> ##[1:4] !code_bp_outside_off)
    else $error("exit did not drop state");
endmodule

bind encres_top encres_top_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .single_step_trap(single_step_trap),
  .code_bp_outside_off(code_bp_outside_off),
  .bp_inside_off(bp_inside_off), .perf_suppress(perf_suppress),
  .demote_other_threads(demote_other_threads)
);

//--- tb_encres_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
  cmp_count++; \
  if ((got) !== (ex)) begin \
    err_count++; \
    $display("ERROR %s exp %h got %h", nm, ex, got); \
  end \
end
module tb_encres_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        single_step_trap;
  logic        code_bp_outside_off;
  logic        bp_inside_off;
  logic        perf_suppress;
  logic        demote_other_threads;
  int          err_count;
  int          cmp_count;
  int          cyc;
  int          traps;
  logic [31:0] cfg [0:16];
  logic [31:0] rd;
  logic        er;
  logic [31:0] e_aep;
  logic [31:0] e_fs;
  logic [31:0] e_gs;

  encres_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .single_step_trap(single_step_trap),
    .code_bp_outside_off(code_bp_outside_off),
    .bp_inside_off(bp_inside_off), .perf_suppress(perf_suppress),
    .demote_other_threads(demote_other_threads)
  );

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  task summarize;
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // trap is a one-cycle pulse, so it is counted here rather than polled
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (single_step_trap === 1'h1)
      traps <= traps + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  function automatic logic [3:0] exp_code(logic [31:0] c);
    logic [31:0] fb;
    logic [31:0] fl;
    logic [31:0] gb;
    logic [31:0] gl;
    logic        nw;
    logic        bad;
    fb = cfg[6] + cfg[10];
    fl = fb + cfg[8];
    gb = cfg[7] + cfg[10];
    gl = gb + cfg[9];
    nw = cfg[11] != 32'hffff_ffff;
    bad = (fl < fb) ? nw : (fl > cfg[11]);
    bad |= (gl < gb) ? nw : (gl > cfg[11]);
    if (cfg[1] != 32'h3) return 4'h1;
    if (cfg[2][11:0] != 12'h0) return 4'h2;
    if (cfg[4][31:1] != 31'h0) return 4'h3;
    if (!cfg[5][0] || !cfg[5][1] || cfg[5][2]) return 4'h4;
    if (c[1] != cfg[5][3]) return 4'h5;
    if (!c[1] && cfg[12][3:0] != 4'h0) return 4'h6;
    if (!c[1] && bad) return 4'h7;
    if (c[3] && !c[2] && cfg[13] != 32'h3) return 4'h8;
    if (c[2] && (cfg[13] & ~cfg[14]) != 32'h0) return 4'h9;
    if (cfg[16] != 32'h0) return 4'ha;
    if ((cfg[15] & ~cfg[13]) != 32'h0) return 4'hb;
    if (!cfg[5][4] || cfg[5][5]) return 4'hc;
    return 4'h0;
  endfunction

  task automatic run_one(input int it);
    logic [31:0] c;
    logic [3:0]  ec;
    logic        ok;
    logic        oi;
    logic        oo;
    int          k;
    int          t0;
    logic [31:0] pf;
    logic [31:0] pg;
    c = $urandom & 32'h0000_009e;
    k = (it < 14) ? it : $urandom_range(20, 0);
    if (it < 14)
      c[1] = 1'h0;
    cfg[1] = 32'h3;
    cfg[2] = $urandom & 32'hffff_f000;
    cfg[3] = $urandom;
    cfg[4] = $urandom & 32'h1;
    cfg[5] = 32'h13 | {28'h0, c[1], 3'h0};
    cfg[6] = $urandom & 32'hff00;
    cfg[7] = $urandom & 32'hff00;
    cfg[8] = $urandom & 32'hfff;
    cfg[9] = $urandom & 32'hfff;
    cfg[10] = $urandom & 32'h00ff_0000;
    cfg[11] = 32'h7fff_ffff;
    cfg[12] = 32'h0;
    cfg[14] = $urandom | 32'h3;
    cfg[13] = c[2] ? (cfg[14] & $urandom) : 32'h3;
    cfg[15] = cfg[13] & $urandom;
    cfg[16] = 32'h0;
    case (k)
      1: cfg[1] = $urandom_range(7, 0);
      2: cfg[2][$urandom_range(11, 0)] = 1'h1;
      3: cfg[4][$urandom_range(31, 1)] = 1'h1;
      4: cfg[5][$urandom_range(2, 0)] ^= 1'h1;
      5: cfg[5][3] ^= 1'h1;
      6: cfg[12][$urandom_range(3, 0)] = 1'h1;
      7: cfg[11] = cfg[10];
      8: cfg[13] = $urandom;
      9: cfg[16][$urandom_range(31, 0)] = 1'h1;
      10: cfg[15] = $urandom;
      11: cfg[5][4 + $urandom_range(1, 0)] ^= 1'h1;
      12: cfg[8] = 32'hffff_ffff;
      13: begin
        cfg[8] = 32'hffff_ffff;
        cfg[11] = 32'hffff_ffff;
      end
      default: ;
    endcase
    for (int i = 1; i < 17; i++)
      apb(1'h1, 8'(i * 4), cfg[i]);
    // load the single-step flag with c[4] from outside, so entry has a value to save
    apb(1'h1, 8'h00, c | 32'h20);
    pf = e_fs;
    pg = e_gs;
    ec = exp_code(c);
    ok = (ec == 4'h0);
    oi = ok & cfg[4][0];
    oo = ok & ~cfg[4][0];
    t0 = traps;
    apb(1'h1, 8'h00, c | 32'h1);
    apb(1'h0, 8'h44, 32'h0);
    while (rd[0] !== 1'h0)
      apb(1'h0, 8'h44, 32'h0);
    `CHK("fault code", ec, rd[11:8])
    `CHK("fault flag", !ok, rd[2])
    `CHK("inside", ok, rd[1])
    `CHK("step pend", oi, rd[3])
    `CHK("trap count", 32'(oi), 32'(traps - t0))
    if (oo) begin
      `CHK("tf saved", c[4], rd[4])
      `CHK("tf now", 1'h0, rd[5])
    end
    `CHK("code bp", ok, code_bp_outside_off)
    `CHK("inside bp", oo, bp_inside_off)
    `CHK("perf", oo, perf_suppress)
    `CHK("demote", oo & c[7], demote_other_threads)
    apb(1'h1, 8'h44, 32'h8);
    if (ok) begin
      e_aep = cfg[3];
      e_fs = cfg[6] + cfg[10];
      e_gs = cfg[7] + cfg[10];
    end
    apb(1'h0, 8'h54, 32'h0);
    `CHK("exit ptr", e_aep, rd)
    apb(1'h0, 8'h4c, 32'h0);
    `CHK("fs base", e_fs, rd)
    apb(1'h0, 8'h50, 32'h0);
    `CHK("gs base", e_gs, rd)
    apb(1'h0, 8'h38, 32'h0);
    `CHK("ext_control_reg_zero", (ok & c[2]) ? cfg[13] : cfg[14], rd)
    if (ok & c[2]) begin
      apb(1'h0, 8'h48, 32'h0);
      `CHK("saved ext_control_reg_zero", cfg[14], rd)
    end
    apb(1'h0, 8'h58, 32'h0);
    `CHK("global stat", {oo, 2'h0, oo, 28'h0}, rd)
    apb(1'h1, 8'h58, 32'h9000_0000);
    if (oo) begin
      apb(1'h1, 8'h00, c | 32'h30);
      apb(1'h0, 8'h44, 32'h0);
      `CHK("tf after pop", 1'h0, rd[5])
    end
    if (ok) begin
      apb(1'h1, 8'h00, c | 32'h40);
      apb(1'h0, 8'h44, 32'h0);
      `CHK("left", 1'h0, rd[1])
      if (oo)
        `CHK("tf back", c[4], rd[5])
      `CHK("bp off", 1'h0, code_bp_outside_off)
      e_fs = pf;
      e_gs = pg;
      apb(1'h0, 8'h4c, 32'h0);
      `CHK("fs back", e_fs, rd)
      apb(1'h0, 8'h50, 32'h0);
      `CHK("gs back", e_gs, rd)
      apb(1'h0, 8'h38, 32'h0);
      `CHK("ext_control_reg_zero back", cfg[14], rd)
    end
  endtask

  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    presetn = 1'h0;
    err_count = 0;
    cmp_count = 0;
    cyc = 0;
    traps = 0;
    e_aep = 32'h0;
    e_fs = 32'h0;
    e_gs = 32'h0;
    void'($urandom(32'h0e24f198));
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 8'h44, 32'h0);
    `CHK("idle status", 32'h0, rd)
    apb(1'h0, 8'h5c, 32'h0);
    `CHK("unmapped err", 1'h1, er)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'h1, 8'h02, 32'h0);
    `CHK("misaligned err", 1'h1, er)
    for (int it = 0; it < 60; it++)
      run_one(it);
    summarize();
  end
endmodule
